// ==== rtl/mrc_ctrl.v ====
// Operation
// - wait row cycle time before calibration
// - two-rank: only no-ops during calibration windows
// - calibrate each rank with own select
// - shared resistor: calibration windows never overlap
// - MR1 bit eight selects refresh protocol
// - banks idle before enabling training
// - training: only bank-zero reads, spaced
// - training exit: wait, load, wait again
// - reset low 200us, then 100 nop clocks
// - after reset: nops, address low 10000 cycles
// - init order MR0, MR1 per die, MR2
// - reserved address and bank bits low on loads
// - loads only with banks idle
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "mrc_map.vh"
module mrc_ctrl
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // device command pins
  output reg dram_reset_n_o,
  output reg die0_select_n_o,
  output reg die1_select_n_o,
  output reg dram_we_n_o,
  output reg dram_ref_n_o,
  output reg [19:0] dram_addr_o,
  output reg [3:0] dram_ba_o,
  // device read data
  input wire [17:0] dram_dq_i,
  input wire read_valid_output_i
);
  localparam S_IDLE = 11'h001;
  localparam S_RSTLO = 11'h002;
  localparam S_PRENOP = 11'h004;
  localparam S_POSTNOP = 11'h008;
  localparam S_MR0 = 11'h010;
  localparam S_MR1 = 11'h020;
  localparam S_CALWAIT = 11'h040;
  localparam S_MR2 = 11'h080;
  localparam S_GAP = 11'h100;
  localparam S_TRAIN = 11'h200;
  localparam S_TRLOAD = 11'h400;
  // register file
  reg [19:0] latency_config_register_r;
  reg [19:0] driver_refresh_config_register_r;
  reg [19:0] training_config_register_r;
  reg [15:0] load_gap_r;
  reg wide_r;
  reg [17:0] rdat_r;
  reg ack_r;
  reg [10:0] state_r;
  reg [10:0] ret_r;
  reg init_go_r;
  reg cal_go_r;
  reg cal_short_r;
  reg cal_die_r;
  reg train_rd_r;
  reg train_exit_r;
  reg init_done_r;
  reg training_r;
  reg die_r;
  reg phase_r;
  reg wt_load_r;
  reg [15:0] wt_cnt_r;
  wire wt_busy;
  wire wt_done;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  wire busy = (state_r != S_IDLE) && (state_r != S_TRAIN);
  wire [15:0] cal_cyc = wide_r ? `MRC_CAL_X36_CYC : `MRC_CAL_X18_CYC;
  assign wb_ack_o = ack_r;
  mrc_wait u_wait
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(wt_load_r),
    .count_i(wt_cnt_r),
    .busy_o(wt_busy),
    .done_o(wt_done)
  );
  // bus slave: one wait state, ack for one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else
    begin
      case (wb_adr_i)
        `MRC_ADR_STAT: wb_dat_o <= {26'h0000000, wt_busy, training_r, init_done_r, busy, 2'h0};
        `MRC_ADR_MR0: wb_dat_o <= {12'h000, latency_config_register_r};
        `MRC_ADR_MR1: wb_dat_o <= {12'h000, driver_refresh_config_register_r};
        `MRC_ADR_MR2: wb_dat_o <= {12'h000, training_config_register_r};
        `MRC_ADR_RDAT: wb_dat_o <= {14'h0000, rdat_r};
        `MRC_ADR_TIME: wb_dat_o <= {16'h0000, load_gap_r};
        `MRC_ADR_CTRL: wb_dat_o <= {27'h0000000, wide_r, 4'h0};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
  // shadow registers kept until rewritten or reset
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latency_config_register_r <= 20'h00000;
      driver_refresh_config_register_r <= `MRC_MR1_RST_VAL;
      training_config_register_r <= 20'h00000;
      load_gap_r <= 16'h0010;
      wide_r <= 1'b0;
      init_go_r <= 1'b0;
      cal_go_r <= 1'b0;
      cal_short_r <= 1'b0;
      cal_die_r <= 1'b0;
      train_rd_r <= 1'b0;
      train_exit_r <= 1'b0;
    end
    else
    begin
      if (state_r == S_RSTLO)
        init_go_r <= 1'b0;
      if (state_r == S_MR1 && !init_done_r || state_r == S_CALWAIT)
        cal_go_r <= 1'b0;
      if (state_r == S_TRAIN && train_rd_r && !wt_busy)
        train_rd_r <= 1'b0;
      if (state_r == S_TRLOAD)
        train_exit_r <= 1'b0;
      if (wr && wb_sel_i[0])
      begin
        case (wb_adr_i)
          `MRC_ADR_MR0: latency_config_register_r <= wb_dat_i[19:0];
          // calibration start bit only set by the sequencer on MR1 loads
          `MRC_ADR_MR1: driver_refresh_config_register_r <= {wb_dat_i[19:8], 1'b0, wb_dat_i[6:0]};
          `MRC_ADR_MR2: training_config_register_r <= wb_dat_i[19:0];
          `MRC_ADR_TIME: load_gap_r <= wb_dat_i[15:0];
          `MRC_ADR_CTRL:
          begin
            wide_r <= wb_dat_i[`MRC_CTRL_WIDE];
            if (wb_dat_i[`MRC_CTRL_INIT] && state_r == S_IDLE)
              init_go_r <= 1'b1;
            // software waits row cycle before ordering calibration
            if (wb_dat_i[`MRC_CTRL_CAL] && state_r == S_IDLE && init_done_r)
            begin
              cal_go_r <= 1'b1;
              cal_short_r <= wb_dat_i[`MRC_CTRL_CALSHORT];
              cal_die_r <= wb_dat_i[`MRC_CTRL_DIE];
            end
            if (wb_dat_i[`MRC_CTRL_RD] && state_r == S_TRAIN)
              train_rd_r <= 1'b1;
            if (wb_dat_i[`MRC_CTRL_TREXIT] && state_r == S_TRAIN)
              train_exit_r <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
  // sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= S_IDLE;
      ret_r <= S_IDLE;
      dram_reset_n_o <= 1'b0;
      die0_select_n_o <= 1'b1;
      die1_select_n_o <= 1'b1;
      dram_we_n_o <= 1'b1;
      dram_ref_n_o <= 1'b1;
      dram_addr_o <= 20'h00000;
      dram_ba_o <= 4'h0;
      init_done_r <= 1'b0;
      training_r <= 1'b0;
      die_r <= 1'b0;
      phase_r <= 1'b0;
      wt_load_r <= 1'b0;
      wt_cnt_r <= 16'h0000;
      rdat_r <= 18'h00000;
    end
    else
    begin
      wt_load_r <= 1'b0;
      // default: nop with address low
      die0_select_n_o <= 1'b1;
      die1_select_n_o <= 1'b1;
      dram_we_n_o <= 1'b1;
      dram_ref_n_o <= 1'b1;
      dram_addr_o <= 20'h00000;
      dram_ba_o <= 4'h0;
      if (read_valid_output_i)
        rdat_r <= dram_dq_i;
      case (state_r)
        S_IDLE:
        begin
          if (init_go_r)
          begin
            init_done_r <= 1'b0;
            training_r <= 1'b0;
            dram_reset_n_o <= 1'b0;
            wt_cnt_r <= `MRC_RST_LOW_CYC;
            wt_load_r <= 1'b1;
            state_r <= S_RSTLO;
          end
          else if (cal_go_r)
          begin
            die_r <= cal_die_r;
            phase_r <= 1'b1;
            state_r <= S_MR1;
          end
          else if (init_done_r && training_config_register_r[`MRC_MR2_TRAIN])
            training_r <= 1'b0;
        end
        S_RSTLO:
          if (wt_done)
          begin
            wt_cnt_r <= `MRC_PRE_NOP_CYC;
            wt_load_r <= 1'b1;
            state_r <= S_PRENOP;
          end
        S_PRENOP:
          if (wt_done)
          begin
            dram_reset_n_o <= 1'b1;
            wt_cnt_r <= `MRC_POST_NOP_CYC;
            wt_load_r <= 1'b1;
            state_r <= S_POSTNOP;
          end
        S_POSTNOP:
          if (wt_done)
            state_r <= S_MR0;
        S_MR0:
        begin
          // die 0, and die 1 too unless wide; reserved bits low
          die0_select_n_o <= 1'b0;
          die1_select_n_o <= wide_r;
          dram_we_n_o <= 1'b0;
          dram_ref_n_o <= 1'b0;
          dram_addr_o <= latency_config_register_r;
          dram_ba_o <= `MRC_BA_MR0;
          die_r <= 1'b0;
          phase_r <= 1'b0;
          wt_cnt_r <= load_gap_r;
          wt_load_r <= 1'b1;
          ret_r <= S_MR1;
          state_r <= S_GAP;
        end
        S_MR1:
        begin
          // one die per load; calibration enabled long at init
          die0_select_n_o <= die_r;
          die1_select_n_o <= wide_r | ~die_r;
          dram_we_n_o <= 1'b0;
          dram_ref_n_o <= 1'b0;
          dram_addr_o <= driver_refresh_config_register_r;
          dram_addr_o[`MRC_MR1_CALEN] <= 1'b1;
          dram_addr_o[`MRC_MR1_CALSEL] <= phase_r ? cal_short_r : 1'b0;
          dram_ba_o <= `MRC_BA_MR1;
          wt_cnt_r <= cal_cyc;
          wt_load_r <= 1'b1;
          state_r <= S_CALWAIT;
        end
        S_CALWAIT:
          // only nops; windows never overlap as next load waits here
          if (wt_done)
          begin
            if (!phase_r && !die_r && !wide_r)
            begin
              die_r <= 1'b1;
              state_r <= S_MR1;
            end
            else if (phase_r)
              state_r <= S_IDLE;
            else
              state_r <= S_MR2;
          end
        S_MR2:
        begin
          die0_select_n_o <= 1'b0;
          die1_select_n_o <= wide_r;
          dram_we_n_o <= 1'b0;
          dram_ref_n_o <= 1'b0;
          dram_addr_o <= training_config_register_r;
          dram_ba_o <= `MRC_BA_MR2;
          wt_cnt_r <= load_gap_r;
          wt_load_r <= 1'b1;
          init_done_r <= 1'b1;
          ret_r <= training_config_register_r[`MRC_MR2_TRAIN] ? S_TRAIN : S_IDLE;
          state_r <= S_GAP;
        end
        S_GAP:
          if (wt_done)
          begin
            training_r <= (ret_r == S_TRAIN);
            state_r <= ret_r;
          end
        S_TRAIN:
        begin
          // software sets training only with banks idle
          if (train_exit_r && !wt_busy)
          begin
            wt_cnt_r <= load_gap_r;
            wt_load_r <= 1'b1;
            state_r <= S_TRLOAD;
          end
          else if (train_rd_r && !wt_busy)
          begin
            // bank-zero read, spacing via gap counter
            die0_select_n_o <= die_r;
            die1_select_n_o <= wide_r | ~die_r;
            dram_ba_o <= `MRC_BA_ZERO;
            die_r <= ~die_r & ~wide_r;
            wt_cnt_r <= load_gap_r;
            wt_load_r <= 1'b1;
          end
        end
        S_TRLOAD:
          if (wt_done)
          begin
            // leave training: reload MR2 with pattern disabled
            die0_select_n_o <= 1'b0;
            die1_select_n_o <= wide_r;
            dram_we_n_o <= 1'b0;
            dram_ref_n_o <= 1'b0;
            dram_addr_o <= training_config_register_r & 20'hFFFFB;
            dram_ba_o <= `MRC_BA_MR2;
            wt_cnt_r <= load_gap_r;
            wt_load_r <= 1'b1;
            ret_r <= S_IDLE;
            state_r <= S_GAP;
          end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // mrc_ctrl
`default_nettype wire

// ==== include/mrc_map.vh ====
`ifndef MRC_MAP_VH
`define MRC_MAP_VH
// wishbone register byte addresses
`define MRC_ADR_CTRL 5'h00
`define MRC_ADR_STAT 5'h04
`define MRC_ADR_MR0 5'h08
`define MRC_ADR_MR1 5'h0C
`define MRC_ADR_MR2 5'h10
`define MRC_ADR_RDAT 5'h14
`define MRC_ADR_TIME 5'h18
// ctrl fields
`define MRC_CTRL_INIT 0
`define MRC_CTRL_CAL 1
`define MRC_CTRL_CALSHORT 2
`define MRC_CTRL_DIE 3
`define MRC_CTRL_WIDE 4
`define MRC_CTRL_TRAIN 5
`define MRC_CTRL_TREXIT 6
`define MRC_CTRL_RD 7
// config register fields
`define MRC_MR1_CALSEL 6
`define MRC_MR1_CALEN 7
`define MRC_MR1_RST_VAL 20'h00000
`define MRC_MR2_TRAIN 2
// bank address and mode register select on the bank bus
`define MRC_BA_MR0 4'h0
`define MRC_BA_MR1 4'h1
`define MRC_BA_MR2 4'h2
`define MRC_BA_ZERO 4'h0
// timing
`define MRC_CLK_MHZ 40
`define MRC_RST_LOW_US 200
// 200 us of device reset at 40 MHz
`define MRC_RST_LOW_CYC 16'h1F40
`define MRC_PRE_NOP_CYC 16'h0064
`define MRC_POST_NOP_CYC 16'h2710
`define MRC_CAL_X18_CYC 16'h0200
`define MRC_CAL_X36_CYC 16'h0400
`define MRC_CNT_W 16
`endif

// ==== rtl/mrc_wait.v ====
`timescale 1ns/100ps
`default_nettype none
// down counter: done pulses when a loaded wait expires
module mrc_wait
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire load_i,
  input wire [15:0] count_i,
  output wire busy_o,
  output wire done_o
);
  reg [15:0] cnt_r;
  reg busy_r;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 16'h0000;
      busy_r <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_r <= count_i;
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r <= 16'h0001)
        busy_r <= 1'b0;
      else
        cnt_r <= cnt_r - 16'h0001;
    end
  end
  assign busy_o = busy_r;
  assign done_o = busy_r && (cnt_r <= 16'h0001) && !load_i;
endmodule // mrc_wait
`default_nettype wire

// ==== tb/mrc_ctrl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module mrc_ctrl_monitor
(
  // clock, reset, bus handshake
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // device command pins
  input wire logic dram_reset_n_o,
  input wire logic die0_select_n_o,
  input wire logic die1_select_n_o,
  input wire logic dram_we_n_o,
  input wire logic dram_ref_n_o,
  input wire logic [19:0] dram_addr_o,
  input wire logic [3:0] dram_ba_o
);
  logic [15:0] low_r, nop_r, hi_r;
  logic [9:0] cal_r;
  wire logic nop = die0_select_n_o & die1_select_n_o;
  wire logic ld = !nop & !dram_we_n_o & !dram_ref_n_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // saturating run-length counters
  always_ff @(posedge clk_i)
  begin
    low_r <= (rst_i || dram_reset_n_o) ? 16'h0 : low_r + {15'h0, low_r != 16'hFFFF};
    nop_r <= (rst_i || dram_reset_n_o || !nop) ? 16'h0 : nop_r + {15'h0, nop_r != 16'hFFFF};
    hi_r <= (rst_i || !dram_reset_n_o) ? 16'h0 : hi_r + {15'h0, hi_r != 16'hFFFF};
    if (rst_i)
      cal_r <= 10'h0;
    else if (ld && dram_ba_o == 4'h1 && dram_addr_o[7])
      cal_r <= 10'h1;
    else
      cal_r <= cal_r + {9'h0, cal_r != 10'h0 && cal_r != 10'h3FF};
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  wb_ack_a: assert property (s_req |=> s_ack)
    else $error("bus answer not a single pulse");
  pins_rst_a: assert property ($fell(rst_i) |-> !dram_reset_n_o && nop && dram_addr_o == 20'h0)
    else $error("pins not idle after reset");
  rst_low_a: assert property ($rose(dram_reset_n_o) |-> low_r >= 16'h1F40)
    else $error("device reset low too short");
  rst_nop_a: assert property ($rose(dram_reset_n_o) |-> nop_r >= 16'h64)
    else $error("too few idle cycles before reset release");
  boot_quiet_a: assert property (dram_reset_n_o && hi_r < 16'h2710 |-> nop && dram_addr_o == 20'h0 && dram_ba_o == 4'h0)
    else $error("command or address during boot quiet time");
  cal_quiet_a: assert property (cal_r != 10'h0 && cal_r < 10'h200 |-> nop)
    else $error("command inside calibration window");
  mr_bank_a: assert property (ld |-> dram_ba_o[3:2] == 2'h0)
    else $error("upper bank bits high on config load");
  mr0_both_a: assert property (ld && dram_ba_o == 4'h0 |-> !die0_select_n_o && !die1_select_n_o)
    else $error("latency register not loaded on both dies");
endmodule // mrc_ctrl_monitor
bind mrc_ctrl mrc_ctrl_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .dram_reset_n_o(dram_reset_n_o), .die0_select_n_o(die0_select_n_o),
  .die1_select_n_o(die1_select_n_o), .dram_we_n_o(dram_we_n_o), .dram_ref_n_o(dram_ref_n_o),
  .dram_addr_o(dram_addr_o), .dram_ba_o(dram_ba_o));
`default_nettype wire

// ==== tb/mrc_dev_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mrc_dev_model
#(
  parameter int CAL_LEN = 512
)
(
  // command pins
  input wire logic clk_i,
  input wire logic dram_reset_n_i,
  input wire logic die0_select_n_i,
  input wire logic die1_select_n_i,
  input wire logic dram_we_n_i,
  input wire logic dram_ref_n_i,
  input wire logic [19:0] dram_addr_i,
  input wire logic [3:0] dram_ba_i,
  // read data and state
  output logic [17:0] dram_dq_o,
  output logic read_valid_output_o,
  output logic [19:0] mr0_o,
  output logic [19:0] mr1_o,
  output logic [19:0] mr2_o,
  output logic [7:0] viol_o
);
  logic mrs_r;
  logic [9:0] cal_r;
  logic [7:0] cnt_r;
  wire logic nop = die0_select_n_i & die1_select_n_i;
  wire logic ld = !nop & !dram_we_n_i & !dram_ref_n_i;
  wire logic rd = !nop & dram_we_n_i & dram_ref_n_i;
  // termination released while read beats are driven
  wire logic term_on = (mr1_o[4:2] != 3'h0) && !read_valid_output_o;
  initial
  begin
    viol_o = 8'h0;
    dram_dq_o = 18'h0;
  end
  always @(posedge clk_i)
  begin
    read_valid_output_o <= mrs_r && cnt_r != 8'h0 && cnt_r <= 8'h4;
    dram_dq_o <= ~dram_dq_o;
    if (cnt_r != 8'h0 && cnt_r <= 8'h4)
      dram_dq_o <= mr2_o[2] ? {18{cnt_r[0]}} ^ (mr2_o[1:0] == 2'h1 ? 18'h2AAAA : 18'h0) : 18'h2D2D3;
    if (cnt_r != 8'h0)
      cnt_r <= cnt_r - 8'h1;
    if (!dram_reset_n_i)
    begin
      mr0_o <= 20'h0;
      mr1_o <= 20'h0;
      mr2_o <= 20'h0;
      mrs_r <= 1'b0;
      cal_r <= 10'h0;
      cnt_r <= 8'h0;
    end
    else if (cal_r != 10'h0)
    begin
      cal_r <= cal_r - 10'h1;
      mr1_o[7] <= cal_r != 10'h1;
      viol_o <= viol_o + {7'h0, !nop};
    end
    else if (ld)
    begin
      viol_o <= viol_o + {7'h0, dram_ba_i[3:2] != 2'h0};
      case (dram_ba_i[1:0])
        2'h0: mr0_o <= dram_addr_i;
        2'h1: mr1_o <= dram_addr_i;
        default: mr2_o <= dram_addr_i;
      endcase
      mrs_r <= mrs_r | (dram_ba_i[1:0] == 2'h0);
      cal_r <= (dram_ba_i[1:0] == 2'h1 && dram_addr_i[7]) ? CAL_LEN[9:0] - 10'h1 : 10'h0;
    end
    else if (rd && mrs_r)
      cnt_r <= {4'h0, mr0_o[3:0]} + 8'h4;
  end
endmodule // mrc_dev_model
`default_nettype wire

// ==== tb/mrc_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mrc_map.vh"
module mrc_ctrl_tb;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk_i, rst_i, cyc, stb, we;
  logic [4:0] adr;
  logic [31:0] wdat;
  wire [31:0] rd_w;
  wire ack_w, rn_w, s0_w, s1_w, we_w, ref_w, vld_w;
  wire [19:0] addr_w, mr0_w, mr1_w, mr2_w;
  wire [3:0] ba_w;
  wire [17:0] dq_w;
  wire [7:0] viol_w;
  int errors = 0;
  int cmp_count = 0;
  mrc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_w), .wb_ack_o(ack_w), .dram_reset_n_o(rn_w),
    .die0_select_n_o(s0_w), .die1_select_n_o(s1_w), .dram_we_n_o(we_w), .dram_ref_n_o(ref_w),
    .dram_addr_o(addr_w), .dram_ba_o(ba_w), .dram_dq_i(dq_w), .read_valid_output_i(vld_w));
  mrc_dev_model dev (.clk_i(clk_i), .dram_reset_n_i(rn_w), .die0_select_n_i(s0_w), .die1_select_n_i(s1_w),
    .dram_we_n_i(we_w), .dram_ref_n_i(ref_w), .dram_addr_i(addr_w), .dram_ba_i(ba_w), .dram_dq_o(dq_w),
    .read_valid_output_o(vld_w), .mr0_o(mr0_w), .mr1_o(mr1_w), .mr2_o(mr2_w), .viol_o(viol_w));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (90000) @(posedge clk_i);
    errors++;
    stop_test;
  end
  task automatic stop_test;
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack_w !== 1'b1 && n++ < 20);
    chk("ack", 32'h1, {31'h0, ack_w});
    q = rd_w;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic poll(input string s, input logic [4:0] a, input logic [31:0] m, v, input int lim);
    logic [31:0] q;
    for (int i = 0; i < lim; i++)
    begin
      wb(1'b0, a, 32'h0, q);
      if ((q & m) === v)
        break;
    end
    chk(s, v, q & m);
  endtask
  task automatic t_regs;
    poll("time", `MRC_ADR_TIME, ALL, 32'h10, 1);
    poll("mr1", `MRC_ADR_MR1, ALL, 32'h0, 1);
    wr(`MRC_ADR_MR0, ALL);
    poll("mr0", `MRC_ADR_MR0, ALL, 32'hFFFFF, 1);
    wr(`MRC_ADR_MR1, 32'h1FF);
    poll("mr1", `MRC_ADR_MR1, ALL, 32'h17F, 1);
    wr(5'h1C, ALL);
    poll("stat", `MRC_ADR_STAT, ALL, 32'h0, 1);
  endtask
  task automatic t_train(input logic [1:0] c, input logic [31:0] e);
    wr(`MRC_ADR_MR0, 32'h3);
    wr(`MRC_ADR_MR1, 32'h103);
    wr(`MRC_ADR_MR2, {29'h0, 1'b1, c});
    wr(`MRC_ADR_CTRL, 32'h1);
    poll("init", `MRC_ADR_STAT, 32'h18, 32'h18, 12000);
    chk("dev mr0", 32'h3, {12'h0, mr0_w});
    chk("dev mr1", 32'h103, {12'h0, mr1_w});
    chk("dev mr2", {29'h0, 1'b1, c}, {12'h0, mr2_w});
    wr(`MRC_ADR_CTRL, 32'h80);
    poll("pattern", `MRC_ADR_RDAT, ALL, e, 40);
    wr(`MRC_ADR_CTRL, 32'h40);
    poll("exit", `MRC_ADR_STAT, 32'h14, 32'h0, 60);
    chk("dev train", 32'h0, {31'h0, mr2_w[2]});
    chk("violations", 32'h0, {24'h0, viol_w});
  endtask
  task automatic t_cal;
    wr(`MRC_ADR_CTRL, 32'h0E);
    poll("cal busy", `MRC_ADR_STAT, 32'h4, 32'h4, 3);
    poll("cal done", `MRC_ADR_STAT, 32'h4, 32'h0, 600);
    chk("dev mr1", 32'h143, {12'h0, mr1_w});
    chk("dev mr0", 32'h3, {12'h0, mr0_w});
    chk("violations", 32'h0, {24'h0, viol_w});
  endtask
  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("dev mr0", 32'h0, {12'h0, mr0_w});
    poll("stat", `MRC_ADR_STAT, ALL, 32'h0, 1);
    poll("mr2", `MRC_ADR_MR2, ALL, 32'h0, 1);
  endtask
  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h0;
    wdat = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_train(2'h0, 32'h3FFFF);
    t_cal;
    t_train(2'h1, 32'h15555);
    t_reset;
    stop_test;
  end
endmodule // mrc_ctrl_tb
`default_nettype wire
